// ==== periph_regs_pkg.sv ====
// constants for the processor peripheral register space: offsets, fields, resets, timing
// assumes a 16-bit word-addressed register bus on the processor side
`default_nettype none
package periph_regs_pkg;
	localparam logic [15:0] OFS_LAST_ACCESS  = 16'hC010;
	localparam logic [15:0] OFS_SERIAL_WORD  = 16'hC011;
	localparam logic [15:0] OFS_REQ_PIN_CTRL = 16'hC012;
	localparam logic [15:0] OFS_DAC_RATE_LO  = 16'hC013;
	localparam logic [15:0] OFS_DAC_RATE_HI  = 16'hC014;
	localparam logic [15:0] OFS_DAC_LEFT     = 16'hC015;
	localparam logic [15:0] OFS_DAC_RIGHT    = 16'hC016;
	localparam logic [15:0] OFS_PIN_DIR      = 16'hC017;
	localparam logic [15:0] OFS_PIN_IN       = 16'hC018;
	localparam logic [15:0] OFS_PIN_OUT      = 16'hC019;
	localparam logic [15:0] OFS_IRQ_MASK     = 16'hC01A;
	localparam logic [15:0] OFS_NEST_INC     = 16'hC01B;
	localparam logic [15:0] OFS_NEST_DEC     = 16'hC01C;
	localparam logic [15:0] OFS_NEST_COUNT   = 16'hC01D;
	// last-access fields
	localparam int          LAST_WRITE_BIT   = 4;
	localparam int          LAST_ADDR_MSB    = 3;
	// interrupt source bit positions
	localparam int          IRQ_TIMER1       = 7;
	localparam int          IRQ_TIMER0       = 6;
	localparam int          IRQ_UART_RX      = 5;
	localparam int          IRQ_UART_TX      = 4;
	localparam int          IRQ_MODULATOR    = 3;
	localparam int          IRQ_SERIAL_DATA  = 2;
	localparam int          IRQ_CONTROL_PORT = 1;
	localparam int          IRQ_DAC          = 0;
	// reset values
	localparam logic [15:0] RST_WORD         = 16'h0000;
	localparam logic [7:0]  RST_MASK         = 8'h00;
	localparam logic [4:0]  RST_NEST         = 5'h00;
	localparam logic [3:0]  RST_PIN          = 4'h0;
	// dac accumulator
	localparam int          DAC_ACC_BITS     = 26;
	localparam int          DAC_STEP_CYCLES  = 4;
	localparam logic [3:0]  DAC_HI_FIELD     = 4'hF;
	// most cycles before mask or nesting writes take hold
	localparam int          IRQ_LAG_MAX      = 6;
	localparam int          IRQ_LAG_USED     = 2;
endpackage
`default_nettype wire

// ==== dsp_peripheral_interrupt_regs.sv ====
// peripheral register space with interrupt mask, nesting counter, dac rate, gpio, serial data
// assumes single-cycle bus strobes from the core on mclk; pins are asynchronous, link events arrive on mclk
`default_nettype none
// Behaviour
// - last-access bit 4 is one after a control-port write, zero after a read
// - last-access bits 3:0 hold the most recent control-port register address
// - serial word returns last two data-port bytes, earlier byte high
// - every four cycles add (high&15)*65536 plus low into 26-bit accumulator
// - accumulator overflow captures left/right samples and raises dac request
// - direction bit 1 makes pin output, 0 makes it input
// - output values are kept while direction selects input
// - input-levels register reads sampled pin levels in bits 3:0
// - gpio never raises an interrupt request
// - enable bits gate sources: 7..0 timer1, timer0, rx, tx, modulator, data, control, dac
// - mask write takes effect within six cycles
// - any write to increment strobe adds one to nesting counter within six cycles
// - any write to decrement strobe subtracts one unless zero, within six cycles
// - nesting counter back at zero delivers enabled interrupts again
// - taking an interrupt adds one to nesting counter
// - nesting counter reads back current value; nonzero blocks all interrupts
module dsp_peripheral_interrupt_regs (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// processor register bus
	input  wire logic [15:0] busAddr,
	input  wire logic        busWrite,
	input  wire logic        busRead,
	input  wire logic [15:0] busWdata,
	output logic      [15:0] busRdata,
	// interrupt to core
	output logic             irqRequest,
	output logic      [2:0]  irqVector,
	input  wire logic        irqTaken,
	// sources from other blocks (same clock, one-cycle pulses)
	input  wire logic [7:1]  srcEvent,
	// control port access event (same clock)
	input  wire logic        ctrlAccess,
	input  wire logic        ctrlAccessWrite,
	input  wire logic [3:0]  ctrlAccessAddr,
	// data serial port byte event (same clock)
	input  wire logic        dataByteValid,
	input  wire logic [7:0]  dataByte,
	// data request pin
	output logic             dataRequestPin,
	// dac sample outputs
	output logic      [15:0] dacLeftOut,
	output logic      [15:0] dacRightOut,
	output logic             dacSampleStrobe,
	// gpio pins
	input  wire logic [3:0]  gpioIn,
	output logic      [3:0]  gpioOut,
	output logic      [3:0]  gpioOe
);
	localparam int ACC = periph_regs_pkg::DAC_ACC_BITS;

	// elaboration guard: the two-bit phase counter only serves a four-cycle step
	if (periph_regs_pkg::DAC_STEP_CYCLES != 4 ||
			periph_regs_pkg::IRQ_LAG_USED > periph_regs_pkg::IRQ_LAG_MAX) begin : g_bad_config
		$error("unsupported timing constants");
	end

	// register state
	logic [5:0]     lastAccess, next_lastAccess;
	logic [15:0]    serialWord, next_serialWord;
	logic           reqPin, next_reqPin;
	logic [15:0]    rateLo, next_rateLo, rateHi, next_rateHi;
	logic [15:0]    left, next_left, right, next_right;
	logic [3:0]     pinDir, next_pinDir, pinOut, next_pinOut;
	logic [7:0]     mask, next_mask, maskLive, next_maskLive;
	logic [4:0]     nest, next_nest;
	logic [7:0]     pending, next_pending;
	logic [ACC-1:0] acc, next_acc;
	logic [1:0]     phase, next_phase;
	logic [15:0]    rdata, next_rdata;
	logic           irqQ, next_irqQ;
	logic [2:0]     vecQ, next_vecQ;
	logic [15:0]    dacL, next_dacL, dacR, next_dacR;
	logic           dacStb, next_dacStb;
	logic [3:0]     pinSync1, pinSync2;
	logic           dacOverflow;
	logic [ACC:0]   accSum;
	logic [7:0]     deliverable;
	logic [7:0]     eventsAll;

	// gpio pins pass two flops before use
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pinSync1 <= periph_regs_pkg::RST_PIN;
			pinSync2 <= periph_regs_pkg::RST_PIN;
		end else begin
			pinSync1 <= gpioIn;
			pinSync2 <= pinSync1;
		end
	end

	// dac rate accumulator, one step per four cycles
	always_comb begin
		accSum      = {1'b0, acc} + (ACC+1)'({rateHi[3:0] & periph_regs_pkg::DAC_HI_FIELD, rateLo});
		dacOverflow = (phase == 2'(periph_regs_pkg::DAC_STEP_CYCLES - 1)) && accSum[ACC];
		next_phase  = phase + 2'h1;
		next_acc    = (phase == 2'(periph_regs_pkg::DAC_STEP_CYCLES - 1)) ? accSum[ACC-1:0] : acc;
		next_dacL   = dacOverflow ? left : dacL;
		next_dacR   = dacOverflow ? right : dacR;
		next_dacStb = dacOverflow;
	end

	// register writes and side effects of the bus
	always_comb begin
		next_lastAccess = lastAccess;
		next_serialWord = serialWord;
		next_reqPin     = reqPin;
		next_rateLo     = rateLo;
		next_rateHi     = rateHi;
		next_left       = left;
		next_right      = right;
		next_pinDir     = pinDir;
		next_pinOut     = pinOut; // kept whatever direction says
		next_mask       = mask;
		next_nest       = nest;
		if (ctrlAccess)
			next_lastAccess = {1'b0, ctrlAccessWrite, ctrlAccessAddr};
		if (dataByteValid)
			next_serialWord = {serialWord[7:0], dataByte}; // earlier byte moves high
		if (busWrite) begin
			case (busAddr)
				periph_regs_pkg::OFS_REQ_PIN_CTRL: next_reqPin = busWdata[0];
				periph_regs_pkg::OFS_DAC_RATE_LO: next_rateLo = busWdata;
				periph_regs_pkg::OFS_DAC_RATE_HI: next_rateHi = busWdata;
				periph_regs_pkg::OFS_DAC_LEFT:    next_left   = busWdata;
				periph_regs_pkg::OFS_DAC_RIGHT:   next_right  = busWdata;
				periph_regs_pkg::OFS_PIN_DIR:     next_pinDir = busWdata[3:0];
				periph_regs_pkg::OFS_PIN_OUT:     next_pinOut = busWdata[3:0];
				periph_regs_pkg::OFS_IRQ_MASK:    next_mask   = busWdata[7:0];
				periph_regs_pkg::OFS_NEST_INC:    next_nest   = nest + 5'h01;
				periph_regs_pkg::OFS_NEST_DEC:    next_nest   = (nest == 5'h00) ? nest : nest - 5'h01;
				periph_regs_pkg::OFS_NEST_COUNT:  next_nest   = busWdata[4:0];
				default:                          next_nest   = nest;
			endcase
		end
		// taking an interrupt bumps the counter; it adds one on top of a bus write in the same cycle
		if (irqTaken && irqQ)
			next_nest = next_nest + 5'h01;
	end

	// pending, mask pipeline and delivery
	always_comb begin
		eventsAll     = {srcEvent, dacOverflow}; // gpio feeds no source
		next_maskLive = mask; // one extra stage keeps lag at two cycles
		next_pending  = pending | eventsAll;
		deliverable   = pending & maskLive;
		next_irqQ     = (deliverable != 8'h00) && (nest == 5'h00) && !(irqTaken && irqQ);
		next_vecQ     = vecQ;
		for (int i = 0; i < 8; i++) begin
			if (deliverable[i])
				next_vecQ = 3'(i); // highest index wins
		end
		if (irqTaken && irqQ)
			next_pending[vecQ] = eventsAll[vecQ]; // a new event in the same cycle wins over the clear
	end

	// read data mux
	always_comb begin
		next_rdata = periph_regs_pkg::RST_WORD;
		if (busRead) begin
			case (busAddr)
				periph_regs_pkg::OFS_LAST_ACCESS: next_rdata = {10'h000, lastAccess};
				periph_regs_pkg::OFS_SERIAL_WORD: next_rdata = serialWord;
				periph_regs_pkg::OFS_DAC_RATE_LO: next_rdata = rateLo;
				periph_regs_pkg::OFS_DAC_RATE_HI: next_rdata = rateHi;
				periph_regs_pkg::OFS_DAC_LEFT:    next_rdata = left;
				periph_regs_pkg::OFS_DAC_RIGHT:   next_rdata = right;
				periph_regs_pkg::OFS_PIN_DIR:     next_rdata = {12'h000, pinDir};
				periph_regs_pkg::OFS_PIN_IN:      next_rdata = {12'h000, pinSync2};
				periph_regs_pkg::OFS_PIN_OUT:     next_rdata = {12'h000, pinOut};
				periph_regs_pkg::OFS_IRQ_MASK:    next_rdata = {8'h00, mask};
				periph_regs_pkg::OFS_NEST_COUNT:  next_rdata = {11'h000, nest};
				default:                          next_rdata = periph_regs_pkg::RST_WORD;
			endcase
		end
	end

	// all state registers except the two pin synchronizer stages
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			lastAccess <= 6'h00;
			serialWord <= periph_regs_pkg::RST_WORD;
			reqPin     <= 1'b0;
			rateLo     <= periph_regs_pkg::RST_WORD;
			rateHi     <= periph_regs_pkg::RST_WORD;
			left       <= periph_regs_pkg::RST_WORD;
			right      <= periph_regs_pkg::RST_WORD;
			pinDir     <= periph_regs_pkg::RST_PIN;
			pinOut     <= periph_regs_pkg::RST_PIN;
			mask       <= periph_regs_pkg::RST_MASK;
			maskLive   <= periph_regs_pkg::RST_MASK;
			nest       <= periph_regs_pkg::RST_NEST;
			pending    <= 8'h00;
			acc        <= '0;
			phase      <= 2'h0;
			rdata      <= periph_regs_pkg::RST_WORD;
			irqQ       <= 1'b0;
			vecQ       <= 3'h0;
			dacL       <= periph_regs_pkg::RST_WORD;
			dacR       <= periph_regs_pkg::RST_WORD;
			dacStb     <= 1'b0;
			gpioOut    <= periph_regs_pkg::RST_PIN;
			gpioOe     <= periph_regs_pkg::RST_PIN;
		end else begin
			lastAccess <= next_lastAccess;
			serialWord <= next_serialWord;
			reqPin     <= next_reqPin;
			rateLo     <= next_rateLo;
			rateHi     <= next_rateHi;
			left       <= next_left;
			right      <= next_right;
			pinDir     <= next_pinDir;
			pinOut     <= next_pinOut;
			mask       <= next_mask;
			maskLive   <= next_maskLive;
			nest       <= next_nest;
			pending    <= next_pending;
			acc        <= next_acc;
			phase      <= next_phase;
			rdata      <= next_rdata;
			irqQ       <= next_irqQ;
			vecQ       <= next_vecQ;
			dacL       <= next_dacL;
			dacR       <= next_dacR;
			dacStb     <= next_dacStb;
			gpioOut    <= next_pinOut;
			gpioOe     <= next_pinDir; // 1 drives the pin
		end
	end

	// outputs straight from flops
	assign busRdata        = rdata;
	assign irqRequest      = irqQ;
	assign irqVector       = vecQ;
	assign dataRequestPin  = reqPin;
	assign dacLeftOut      = dacL;
	assign dacRightOut     = dacR;
	assign dacSampleStrobe = dacStb;

	// checks: nesting counter, a take in the same cycle is left out where it adds its own one
	AST_NEST_INC: assert property (@(posedge mclk) disable iff (sys_rst)
		busWrite && busAddr == periph_regs_pkg::OFS_NEST_INC && !(irqTaken && irqQ) |=> nest == $past(nest) + 5'h01)
		else $error("nest increment lost");
	AST_NEST_DEC: assert property (@(posedge mclk) disable iff (sys_rst)
		busWrite && busAddr == periph_regs_pkg::OFS_NEST_DEC && nest != 5'h00 && !(irqTaken && irqQ)
		|=> nest == $past(nest) - 5'h01) else $error("nest decrement wrong");
	AST_NEST_FLOOR: assert property (@(posedge mclk) disable iff (sys_rst)
		busWrite && busAddr == periph_regs_pkg::OFS_NEST_DEC && nest == 5'h00 && !irqTaken |=> nest == 5'h00)
		else $error("nest underflow");
	AST_TAKEN: assert property (@(posedge mclk) disable iff (sys_rst)
		irqTaken && irqRequest && !busWrite |=> nest == $past(nest) + 5'h01)
		else $error("take not counted");

	// checks: delivery to the core
	AST_BLOCKED: assert property (@(posedge mclk) disable iff (sys_rst)
		$past(nest) != 5'h00 |-> !irqRequest)
		else $error("irq while nested");
	sequence sqEnabledPending;
		nest == 5'h00 && (pending & maskLive) != 8'h00 && !irqTaken;
	endsequence
	AST_DELIVER: assert property (@(posedge mclk) disable iff (sys_rst)
		sqEnabledPending |=> irqRequest)
		else $error("enabled pending not delivered");
	AST_MASKED_HELD: assert property (@(posedge mclk) disable iff (sys_rst)
		(pending & maskLive) == 8'h00 |=> !irqRequest)
		else $error("request without enabled pending source");
	AST_VECTOR: assert property (@(posedge mclk) disable iff (sys_rst)
		irqRequest |-> pending[irqVector])
		else $error("vector names no pending source");
	AST_TAKE_DROPS: assert property (@(posedge mclk) disable iff (sys_rst)
		irqTaken && irqRequest |=> !irqRequest)
		else $error("request held after take");
	AST_MASK_LAG: assert property (@(posedge mclk) disable iff (sys_rst)
		busWrite && busAddr == periph_regs_pkg::OFS_IRQ_MASK |-> ##2 maskLive == $past(busWdata[7:0], 2))
		else $error("mask lag too long");

	// checks: data paths and pins
	AST_SERIAL: assert property (@(posedge mclk) disable iff (sys_rst)
		dataByteValid |=> serialWord == {$past(serialWord[7:0]), $past(dataByte)})
		else $error("serial order");
	AST_LAST: assert property (@(posedge mclk) disable iff (sys_rst)
		ctrlAccess |=> lastAccess[4:0] == {$past(ctrlAccessWrite), $past(ctrlAccessAddr)})
		else $error("last access wrong");
	AST_DAC: assert property (@(posedge mclk) disable iff (sys_rst)
		dacOverflow |=> dacSampleStrobe && pending[periph_regs_pkg::IRQ_DAC])
		else $error("dac event lost");
	AST_DAC_SINGLE: assert property (@(posedge mclk) disable iff (sys_rst)
		dacSampleStrobe |=> !dacSampleStrobe)
		else $error("dac strobe longer than one cycle");
	AST_GPIO_OE: assert property (@(posedge mclk) disable iff (sys_rst)
		busWrite && busAddr == periph_regs_pkg::OFS_PIN_DIR |=> gpioOe == $past(busWdata[3:0]))
		else $error("direction wrong");
	AST_GPIO_KEEP: assert property (@(posedge mclk) disable iff (sys_rst)
		busWrite && busAddr == periph_regs_pkg::OFS_PIN_DIR |=> gpioOut == $past(gpioOut))
		else $error("output values lost on direction change");
endmodule
`default_nettype wire

// ==== irq_core_model.sv ====
// core-side model: accepts a delivered interrupt after a chosen lag
// assumes mclk shared with the register block; drives on the falling edge
`default_nettype none
module irq_core_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// interrupt handshake
	input  wire logic       irqRequest,
	input  wire logic [3:0] lag,
	output logic            irqTaken
);
	timeunit 1ns;
	timeprecision 1ns;
	// one-cycle accept, then a rest so a falling request is not taken twice
	initial begin
		irqTaken = 1'b0;
		forever begin
			@(negedge mclk);
			if (!sys_rst && irqRequest === 1'b1) begin
				repeat (lag) @(negedge mclk);
				irqTaken = irqRequest === 1'b1; // withdrawn requests are left alone
				@(negedge mclk);
				irqTaken = 1'b0;
				repeat (3) @(negedge mclk);
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// bench for the peripheral register block: bus tasks, event pulses, core model
// assumes a 10 MHz mclk; inputs change on the falling edge only
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, sys_rst, busWrite, busRead, irqTaken, ctrlAccess, ctrlAccessWrite, dataByteValid;
	logic [15:0] busAddr, busWdata, busRdata, dacLeftOut, dacRightOut;
	logic [7:1]  srcEvent;
	logic [7:0]  dataByte;
	logic [3:0]  ctrlAccessAddr, gpioIn, gpioOut, gpioOe, lag;
	logic [2:0]  irqVector;
	logic        irqRequest, dataRequestPin, dacSampleStrobe;
	int          error_cnt, n_compared, cycles, n;
	logic [15:0] rstA [12] = '{16'hC010, 16'hC011, 16'hC013, 16'hC014, 16'hC015, 16'hC016,
		16'hC017, 16'hC018, 16'hC019, 16'hC01A, 16'hC01D, 16'hC020};
	logic [15:0] rwA [8] = '{16'hC013, 16'hC014, 16'hC015, 16'hC016, 16'hC017, 16'hC019, 16'hC01A, 16'hC01D};
	logic [15:0] rwM [8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h000F, 16'h000F, 16'h00FF, 16'h001F};

	dsp_peripheral_interrupt_regs u_dsp_peripheral_interrupt_regs (.mclk, .sys_rst, .busAddr, .busWrite,
		.busRead, .busWdata, .busRdata, .irqRequest, .irqVector, .irqTaken, .srcEvent, .ctrlAccess,
		.ctrlAccessWrite, .ctrlAccessAddr, .dataByteValid, .dataByte, .dataRequestPin, .dacLeftOut,
		.dacRightOut, .dacSampleStrobe, .gpioIn, .gpioOut, .gpioOe);
	irq_core_model u_irq_core_model (.mclk, .sys_rst, .irqRequest, .lag, .irqTaken);

	// free-running clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// hang guard, well above the expected run of about 2400 cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge mclk);
		busAddr = a;
		busWdata = d;
		busWrite = 1'b1;
		@(negedge mclk);
		busWrite = 1'b0;
	endtask

	// read data shows for the one cycle after the taking edge
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(negedge mclk);
		busAddr = a;
		busRead = 1'b1;
		@(negedge mclk);
		busRead = 1'b0;
		chk($sformatf("reg %h", a), exp, busRdata);
	endtask

	task automatic pulse(input int i);
		@(negedge mclk);
		srcEvent[i] = 1'b1;
		@(negedge mclk);
		srcEvent = 7'h00;
	endtask

	task automatic ctrl(input logic w, input logic [3:0] a);
		@(negedge mclk);
		{ctrlAccess, ctrlAccessWrite, ctrlAccessAddr} = {1'b1, w, a};
		@(negedge mclk);
		ctrlAccess = 1'b0;
	endtask

	task automatic sbyte(input logic [7:0] b);
		@(negedge mclk);
		{dataByteValid, dataByte} = {1'b1, b};
		@(negedge mclk);
		dataByteValid = 1'b0;
	endtask

	// bounded wait: lag allowance plus the registered request
	task automatic irq_on(input logic [2:0] vec);
		n = 0;
		while (irqRequest !== 1'b1 && n < 9) begin
			@(negedge mclk);
			n++;
		end
		chk("irqRequest", 16'h0001, {15'h0000, irqRequest});
		chk("irqVector", {13'h0000, vec}, {13'h0000, irqVector});
	endtask

	task automatic quiet(input int c);
		repeat (c) begin
			@(negedge mclk);
			chk("irqRequest", 16'h0000, {15'h0000, irqRequest});
		end
	endtask

	// main sequence
	initial begin
		{sys_rst, busWrite, busRead, ctrlAccess, ctrlAccessWrite, dataByteValid} = 6'h20;
		{busAddr, busWdata, srcEvent, dataByte, ctrlAccessAddr, gpioIn, lag} = '0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 1'b0;
		foreach (rstA[k]) rd(rstA[k], 16'h0000);
		foreach (rwA[k]) begin
			wr(rwA[k], 16'hFFFF);
			rd(rwA[k], rwM[k]);
			wr(rwA[k], 16'h0000);
		end
		wr(16'hC012, 16'h0001);
		chk("dataRequestPin", 16'h0001, {15'h0000, dataRequestPin});
		// gpio: direction, kept outputs, input sampling, no interrupts
		wr(16'hC017, 16'h000A);
		wr(16'hC019, 16'h0006);
		chk("gpioOe", 16'h000A, {12'h000, gpioOe});
		chk("gpioOut", 16'h0002, {12'h000, gpioOut & gpioOe});
		wr(16'hC017, 16'h0000);
		rd(16'hC019, 16'h0006);
		wr(16'hC017, 16'h000F);
		chk("gpioOut", 16'h0006, {12'h000, gpioOut});
		wr(16'hC01A, 16'h00FF);
		gpioIn = 4'h9;
		quiet(8);
		rd(16'hC018, 16'h0009);
		wr(16'hC01A, 16'h0000);
		ctrl(1'b1, 4'hB);
		rd(16'hC010, 16'h001B);
		ctrl(1'b0, 4'h3);
		rd(16'hC010, 16'h0003);
		sbyte(8'h12);
		sbyte(8'h34);
		sbyte(8'h56);
		rd(16'hC011, 16'h3456);
		// sources 1 to 7 alone, prompt to slow acceptance
		for (int i = 1; i < 8; i++) begin
			lag = i[3:0];
			wr(16'hC01A, 16'h0001 << i);
			pulse(i);
			irq_on(i[2:0]);
			repeat (12) @(negedge mclk);
			rd(16'hC01D, 16'h0001);
			wr(16'hC01C, 16'h0000);
			rd(16'hC01D, 16'h0000);
		end
		// a masked event is held until enabled
		wr(16'hC01A, 16'h0000);
		pulse(7);
		quiet(8);
		wr(16'hC01A, 16'h0080);
		irq_on(3'h7);
		repeat (12) @(negedge mclk);
		wr(16'hC01C, 16'h0000);
		// nesting: two blocks, release one at a time
		wr(16'hC01B, 16'h1234);
		wr(16'hC01B, 16'h0000);
		rd(16'hC01D, 16'h0002);
		wr(16'hC01A, 16'h0004);
		pulse(2);
		quiet(8);
		wr(16'hC01C, 16'h0000);
		quiet(8);
		wr(16'hC01C, 16'hFFFF);
		irq_on(3'h2);
		repeat (12) @(negedge mclk);
		rd(16'hC01D, 16'h0001);
		wr(16'hC01C, 16'h0000);
		wr(16'hC01C, 16'h0000);
		rd(16'hC01D, 16'h0000);
		// dac: step 4*65536 on a 26-bit sum overflows every 256 steps
		wr(16'hC01A, 16'h0000);
		wr(16'hC015, 16'h1234);
		wr(16'hC016, 16'hA5C3);
		wr(16'hC014, 16'h0074);
		n = 0;
		while (dacSampleStrobe !== 1'b1 && n < 1100) begin
			@(negedge mclk);
			n++;
		end
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (dacSampleStrobe !== 1'b1 && n < 1100);
		chk("dac period", 16'h0400, n[15:0]);
		chk("dacLeftOut", 16'h1234, dacLeftOut);
		chk("dacRightOut", 16'hA5C3, dacRightOut);
		wr(16'hC01A, 16'h0001);
		irq_on(3'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
